// File: hdl/sem_pkg.sv
// Shared constants and types of the serial link fault monitor
package sem_pkg;

  // ----------------------------------------------------------------
  // Word and command layout
  // ----------------------------------------------------------------
  localparam int          WORD_W        = 16;
  localparam int          NUM_W         = 5;
  localparam int          OFF_W         = 10;
  localparam int          FAULT_W       = 3;
  localparam int          RSV_W         = WORD_W - FAULT_W;
  localparam logic [9:0]  FAULT_REG_OFF = 10'h1D3;
  localparam logic [15:0] FAULT_RD_CMD  = 16'hBA61;
  localparam logic [15:0] SEL_GENERIC   = 16'h0004;
  localparam logic [12:0] DIAG_PATTERN  = 13'h1555;
  localparam logic [15:0] FAULT_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // Fault codes, one bit each
  // ----------------------------------------------------------------
  localparam logic [2:0]  F_NONE  = 3'h0;
  localparam logic [2:0]  F_WORD  = 3'h1;
  localparam logic [2:0]  F_FRAME = 3'h2;
  localparam logic [2:0]  F_CKSYS = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WDOG_STEP_NS  = 1600;
  localparam int WDOG_STEP_CYC =
    (WDOG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             rd;
    logic [OFF_W-1:0] offset;
    logic [NUM_W-1:0] num;
  } sem_cmd_type;

  typedef struct packed {
    logic       mode_b;
    logic       irq_en;
    logic [3:0] wdog_limit;
  } sem_cfg_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_DATA  = 5'h02,
    ST_DONE  = 5'h04,
    ST_ERROR = 5'h08,
    ST_REPLY = 5'h10
  } sem_state_type;

endpackage

// File: hdl/sem_link.sv
// Link-clock side: bit counting, word capture and MISO drive
`timescale 1ns/1ps
`default_nettype none
module sem_link (
  // Link clock and resets
  input  wire logic        link_clk,
  input  wire logic        rst_n,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // From core domain, static levels
  input  wire logic [2:0]  tx_fault,
  input  wire logic        tx_reply,
  // To core domain
  output logic [15:0]      rx_word,
  output logic             rx_toggle,
  output logic             partial
);
  import sem_pkg::*;

  logic             fresh_q;
  logic [3:0]       cnt_q;
  logic [3:0]       cnt_d;
  logic [14:0]      sh_q;
  logic [3:0]       tx1_q;
  logic [3:0]       tx2_q;
  logic [15:0]      tx_word;
  logic [3:0]       idx;

  // ----------------------------------------------------------------
  // Frame start marker, set by chip select high
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit counter and receive shifter
  // ----------------------------------------------------------------
  assign cnt_d = fresh_q ? 4'h1 : cnt_q + 4'h1;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 4'h0;
      partial   <= 1'b0;
      sh_q      <= 15'h0000;
      rx_word   <= 16'h0000;
      rx_toggle <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      partial <= (cnt_d != 4'h0);
      sh_q    <= fresh_q ? {14'h0000, mosi} : {sh_q[13:0], mosi};
      if (cnt_d == 4'h0) begin
        rx_word   <= {sh_q, mosi};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit word, fault bits cross as levels
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx1_q <= 4'h0;
      tx2_q <= 4'h0;
    end else begin
      tx1_q <= {tx_reply, tx_fault};
      tx2_q <= tx1_q;
    end
  end

  // Reply words carry zero above the fault code; the reply flag is stale
  // at frame start, so the first bit always shows the pattern
  assign tx_word = {((tx2_q[3] && !fresh_q) ? 13'h0000 : DIAG_PATTERN),
                    tx2_q[2:0]};
  assign idx     = fresh_q ? 4'hF : ~cnt_q;
  assign miso    = tx_word[idx];
  assign miso_oe = ~cs_n;

endmodule // sem_link
`default_nettype wire

// File: hdl/sem_monitor.sv
// Fault monitor of the serial slave: latch, error state, reply, irq
//
// Behaviour
// - Three read-only fault flags, reset zero
// - Write words echo fixed thirteen-bit pattern
// - Diagnostic low three bits mirror fault flags
// - First fault latched, later faults ignored
// - Latched fault raises irq when enabled
// - Error state admits only fault-read command
// - Fault read sends one word, clears error
// - Generic target: code returned, flags cleared
// - Other target: undefined word, flags kept
// - Chip select low without clock: flag
// - Burst word count mismatch: frame flag
// - Timed mode inter-word timeout: frame flag
// - Select-delimited mode count mismatch: frame flag
// - Wrong bit count in word: word flag
// - No fault reads all zeros
// - Timeout limit from configuration field
// - Early select rise or extra words: error in select-delimited mode
`timescale 1ns/1ps
`default_nettype none
module sem_monitor #(
  parameter int WDOG_CNT_W = 12
) (
  // Clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // Serial link pins
  input  wire logic                spi_sclk,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_mosi,
  output logic                     spi_miso,
  output logic                     spi_miso_oe,
  // Configuration and system status
  input  wire sem_pkg::sem_cfg_type cfg,
  input  wire logic [15:0]         sel_value,
  input  wire logic                cksys_ok,
  // Accepted words toward the protocol
  output logic                     word_valid,
  output logic [15:0]              word_data,
  output logic                     word_is_cmd,
  // Status
  output logic [15:0]              fault_status,
  output logic                     err_state,
  output logic                     irq
);
  import sem_pkg::*;

  logic [1:0]                rst_q;
  logic                      rst_n;
  logic [3:0]                s1_q;
  logic [3:0]                s2_q;
  logic                      cs_prev_q;
  logic                      tgl_prev_q;
  logic                      cs_s;
  logic                      cksys_s;
  logic                      tgl_s;
  logic                      part_s;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      word_evt;
  logic [15:0]               link_word;
  logic                      link_tgl;
  logic                      link_part;
  sem_cmd_type               cmd;
  sem_state_type             state_q;
  logic [NUM_W-1:0]          num_q;
  logic [NUM_W-1:0]          left_q;
  logic [WDOG_CNT_W-1:0]     wdog_q;
  logic [WDOG_CNT_W-1:0]     wdog_lim;
  logic                      wdog_run;
  logic                      wdog_hit;
  logic                      ev_cksys;
  logic                      ev_frame;
  logic                      ev_word;
  logic [2:0]                fault_new;
  logic [2:0]                fault_q;
  logic                      fault_take;
  logic                      fault_clr;
  logic                      reply_done;
  logic                      reply_clear_q;
  logic                      sel_generic_q;
  logic                      irq_pend_q;
  logic [2:0]                tx_fault_q;
  logic                      tx_reply_q;
  logic                      cmd_is_fault_rd;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  sem_link u_link (
    .link_clk  (spi_sclk),
    .rst_n     (rst_n),
    .cs_n      (spi_cs_n),
    .mosi      (spi_mosi),
    .miso      (spi_miso),
    .miso_oe   (spi_miso_oe),
    .tx_fault  (tx_fault_q),
    .tx_reply  (tx_reply_q),
    .rx_word   (link_word),
    .rx_toggle (link_tgl),
    .partial   (link_part)
  );

  // ----------------------------------------------------------------
  // Synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q       <= 4'h1;
      s2_q       <= 4'h1;
      cs_prev_q  <= 1'b1;
      tgl_prev_q <= 1'b0;
    end else if (clk_en) begin
      s1_q       <= {link_part, link_tgl, cksys_ok, spi_cs_n};
      s2_q       <= s1_q;
      cs_prev_q  <= cs_s;
      tgl_prev_q <= tgl_s;
    end
  end

  assign cs_s     = s2_q[0];
  assign cksys_s  = s2_q[1];
  assign tgl_s    = s2_q[2];
  assign part_s   = s2_q[3];
  assign cs_fall  = cs_prev_q & ~cs_s;
  assign cs_rise  = ~cs_prev_q & cs_s;
  // Word held by the link until the next sixteen bits
  assign word_evt = tgl_s ^ tgl_prev_q;
  assign cmd      = sem_cmd_type'(link_word);
  assign cmd_is_fault_rd = cmd.rd && (cmd.offset == FAULT_REG_OFF);

  // ----------------------------------------------------------------
  // Inter-word watchdog for timed framing
  // ----------------------------------------------------------------
  assign wdog_lim = WDOG_CNT_W'(cfg.wdog_limit) *
                    WDOG_CNT_W'(WDOG_STEP_CYC);
  assign wdog_run = (state_q == ST_DATA) && !cfg.mode_b &&
                    (num_q != '0);
  assign wdog_hit = wdog_run && (wdog_q >= wdog_lim);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_q <= '0;
    end else if (clk_en) begin
      if (!wdog_run || word_evt) begin
        wdog_q <= '0;
      end else if (!wdog_hit) begin
        wdog_q <= wdog_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault detection and first-fault latch
  // ----------------------------------------------------------------
  assign ev_cksys = cs_fall && !cksys_s;
  assign ev_frame = wdog_hit ||
                    ((state_q == ST_DATA) && cfg.mode_b && cs_rise &&
                     (num_q != '0) && (left_q != '0)) ||
                    ((state_q == ST_DONE) && word_evt);
  assign ev_word  = cs_rise && part_s;

  always_comb begin
    if (ev_cksys) begin
      fault_new = F_CKSYS;
    end else if (ev_frame) begin
      fault_new = F_FRAME;
    end else if (ev_word) begin
      fault_new = F_WORD;
    end else begin
      fault_new = F_NONE;
    end
  end

  assign reply_done = (state_q == ST_REPLY) && word_evt;
  assign fault_clr  = reply_done && reply_clear_q;
  // A fault in the clearing cycle still gets latched
  assign fault_take = (fault_new != F_NONE) &&
                      ((fault_q == F_NONE) || fault_clr);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q       <= FAULT_RST[2:0];
      sel_generic_q <= 1'b0;
    end else if (clk_en) begin
      if (fault_take) begin
        fault_q       <= fault_new;
        sel_generic_q <= (sel_value == SEL_GENERIC);
      end else if (fault_clr) begin
        fault_q <= F_NONE;
      end
    end
  end

  // Writes from the link never reach this register
  assign fault_status = {{RSV_W{1'b0}}, fault_q};

  // ----------------------------------------------------------------
  // Protocol tracking and error state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      num_q         <= '0;
      left_q        <= '0;
      reply_clear_q <= 1'b0;
    end else if (clk_en) begin
      if (fault_take) begin
        state_q <= ST_ERROR;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (word_evt) begin
              num_q  <= cmd.num;
              left_q <= cmd.num;
              if (cmd_is_fault_rd) begin
                state_q       <= ST_REPLY;
                reply_clear_q <= (sel_value == SEL_GENERIC);
              end else if (cmd.num != '0 || cfg.mode_b) begin
                state_q <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (word_evt && num_q != '0) begin
              left_q <= left_q - 1'b1;
              if (left_q == 5'h01) begin
                state_q <= cfg.mode_b ? ST_DONE : ST_IDLE;
              end
            end else if (cs_rise && (cfg.mode_b || num_q == '0)) begin
              state_q <= ST_IDLE;
            end
          end
          ST_DONE: begin
            if (cs_rise) begin
              state_q <= ST_IDLE;
            end
          end
          ST_ERROR: begin
            if (word_evt && link_word == FAULT_RD_CMD) begin
              state_q       <= ST_REPLY;
              reply_clear_q <= sel_generic_q;
            end
          end
          ST_REPLY: begin
            if (word_evt) begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flag, interrupt and link transmit levels
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_state  <= 1'b0;
      irq_pend_q <= 1'b0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (fault_take) begin
        err_state  <= 1'b1;
        irq_pend_q <= 1'b1;
      end else if (reply_done) begin
        err_state  <= 1'b0;
        irq_pend_q <= 1'b0;
      end
      irq <= irq_pend_q && cfg.irq_en;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fault_q <= F_NONE;
      tx_reply_q <= 1'b0;
    end else if (clk_en) begin
      tx_reply_q <= (state_q == ST_REPLY);
      // Other targets get an undefined reply, sent as zero
      if ((state_q == ST_REPLY) && !reply_clear_q) begin
        tx_fault_q <= F_NONE;
      end else begin
        tx_fault_q <= fault_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accepted words toward the protocol
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid  <= 1'b0;
      word_data   <= 16'h0000;
      word_is_cmd <= 1'b0;
    end else if (clk_en) begin
      // Nothing passes in error or reply slots
      word_valid <= word_evt && !fault_take &&
                    ((state_q == ST_DATA) ||
                     ((state_q == ST_IDLE) && !cmd_is_fault_rd));
      if (word_evt) begin
        word_data   <= link_word;
        word_is_cmd <= (state_q == ST_IDLE);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  a_cksys_flag: assert property (
    ev_cksys && fault_q == F_NONE |=> fault_q == F_CKSYS)
    else $error("missing clock not flagged");
  a_first_latch: assert property (
    fault_q != F_NONE && !fault_clr |=> fault_q == $past(fault_q))
    else $error("latched fault changed");
  a_irq_raise: assert property (
    fault_take && cfg.irq_en ##1 cfg.irq_en |=> irq)
    else $error("irq not raised");
  a_err_block: assert property (
    state_q == ST_ERROR |=> !word_valid)
    else $error("word passed in error state");
  a_reply_clear: assert property (
    reply_done && reply_clear_q && !fault_take
      |=> fault_q == F_NONE && !err_state ##1 !irq)
    else $error("generic reply did not clear");
  a_other_keep: assert property (
    reply_done && !reply_clear_q && !fault_take
      |=> fault_q == $past(fault_q) && !err_state)
    else $error("other-target reply wrong");
  a_wdog_fault: assert property (
    wdog_hit && fault_q == F_NONE && !ev_cksys |=> fault_q == F_FRAME)
    else $error("timeout not flagged");
  a_frame_count: assert property (
    state_q == ST_DONE && word_evt && fault_q == F_NONE && !ev_cksys
      |=> fault_q == F_FRAME && state_q == ST_ERROR)
    else $error("extra word not flagged");
  a_word_bits: assert property (
    ev_word && !ev_cksys && !ev_frame && fault_q == F_NONE
      |=> fault_q == F_WORD)
    else $error("bit count fault not flagged");
  a_reserved_zero: assert property (
    fault_status[15:3] == '0 && $onehot0(fault_q))
    else $error("reserved bits or code invalid");

  c_reply: cover property (reply_done && reply_clear_q);
  c_timeout: cover property (wdog_hit);
  c_extra_word: cover property (state_q == ST_DONE && word_evt);
  c_word_fault: cover property (ev_word);

endmodule // sem_monitor
`default_nettype wire

// File: verification/sem_master.sv
// Serial master model that drives frames into the fault monitor
`timescale 1ns/1ps
`default_nettype none
module sem_master (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Link clock idles low and only toggles inside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  task automatic open_frame();
    cs_n = 1'b0;
    #1000;
  endtask

  // Released data line shows the inverse, not the last value
  task automatic close_frame();
    cs_n = 1'b1;
    mosi = ~mosi;
    #1000;
  endtask

  // ----------------------------------------------------------------
  // Word transfer
  // ----------------------------------------------------------------
  // Mode 0, MSB first; fewer than 16 bits give a broken word
  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[15-i];
      #62.5;
      rx = {rx[14:0], miso};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    mosi = ~mosi;
    #1000;
  endtask
endmodule // sem_master
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the serial link fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sem_pkg::*;
  logic        core_clk        = 1'b0;
  logic        resetn          = 1'b0;
  logic        clk_en          = 1'b1;
  logic        cksys_ok        = 1'b1;
  sem_cfg_type cfg             = '0;
  logic [15:0] sel_value       = SEL_GENERIC;
  wire  logic  sclk, cs_n, mosi, miso;
  logic        miso_oe, word_valid, word_is_cmd, err_state, irq;
  logic [15:0] word_data, fault_status, rx;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          wv_cnt          = 0;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (word_valid) wv_cnt <= wv_cnt + 1;

  sem_monitor sem_monitor_inst (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .cfg(cfg),
    .sel_value(sel_value), .cksys_ok(cksys_ok), .word_valid(word_valid),
    .word_data(word_data), .word_is_cmd(word_is_cmd),
    .fault_status(fault_status), .err_state(err_state), .irq(irq));
  sem_master sem_master_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wait_err(input logic exp);
    int n;
    n = 0;
    while (err_state !== exp && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) begin
      check("err_state wait", {15'h0, err_state}, {15'h0, exp});
      give_verdict();
    end
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic setup(input logic mb, input logic ie,
                       input logic [3:0] wl, input logic [15:0] sel);
    @(posedge core_clk);
    cfg <= '{mode_b: mb, irq_en: ie, wdog_limit: wl};
    sel_value <= sel;
    repeat (4) @(posedge core_clk);
  endtask

  // Write frame of n data words, each answer must be a diagnostic word
  task automatic wframe(input logic [15:0] cmd, input int n,
                        input logic [2:0] code);
    sem_master_inst.open_frame();
    check("miso enable", {15'h0, miso_oe}, 16'h0001);
    for (int i = 0; i <= n; i++) begin
      sem_master_inst.xfer(i == 0 ? cmd : 16'hFFFF, 16, rx);
      check("diag word", rx, {DIAG_PATTERN, code});
      check("diag low", {13'h0, rx[2:0]}, {13'h0, code});
    end
    sem_master_inst.close_frame();
  endtask

  task automatic expect_fault(input logic [2:0] code, input logic ie);
    wait_err(1'b1);
    check("fault status", fault_status, {13'h0, code});
    check("irq", {15'h0, irq}, {15'h0, ie});
  endtask

  task automatic recover(input logic [2:0] code, input logic generic);
    sem_master_inst.open_frame();
    sem_master_inst.xfer(FAULT_RD_CMD, 16, rx);
    sem_master_inst.xfer(16'h0000, 16, rx);
    sem_master_inst.close_frame();
    check("reply", {13'h0, rx[2:0]}, generic ? {13'h0, code} : 16'h0);
    wait_err(1'b0);
    check("irq after reply", {15'h0, irq}, 16'h0000);
    check("kept status", fault_status, generic ? 16'h0 : {13'h0, code});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_clean();
    int v;
    setup(1'b1, 1'b1, 4'h4, SEL_GENERIC);
    check("reset status", fault_status, FAULT_RST);
    check("reset err", {15'h0, err_state}, 16'h0000);
    v = wv_cnt;
    wframe({1'b0, FAULT_REG_OFF, 5'h01}, 1, F_NONE);
    check("words taken", 16'(wv_cnt - v), 16'h0002);
    check("last word", word_data, 16'hFFFF);
    check("data flag", {15'h0, word_is_cmd}, 16'h0000);
    check("status after write", fault_status, 16'h0000);
    $display("test clean write done");
  endtask

  task automatic t_word_err();
    int v;
    sem_master_inst.open_frame();
    sem_master_inst.xfer({1'b0, 10'h194, 5'h00}, 16, rx);
    sem_master_inst.xfer(16'h1234, 9, rx);
    sem_master_inst.close_frame();
    expect_fault(F_WORD, 1'b1);
    v = wv_cnt;
    @(posedge core_clk);
    cksys_ok <= 1'b0;
    wframe({1'b0, 10'h194, 5'h01}, 1, F_WORD);
    @(posedge core_clk);
    cksys_ok <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("first fault kept", fault_status, {13'h0, F_WORD});
    check("words dropped", 16'(wv_cnt - v), 16'h0000);
    recover(F_WORD, 1'b1);
    $display("test word error done");
  endtask

  task automatic t_frame_short();
    setup(1'b1, 1'b0, 4'h4, 16'h0001);
    sem_master_inst.open_frame();
    sem_master_inst.xfer({1'b0, 10'h194, 5'h02}, 16, rx);
    sem_master_inst.xfer(16'h00A5, 16, rx);
    sem_master_inst.close_frame();
    expect_fault(F_FRAME, 1'b0);
    recover(F_FRAME, 1'b0);
    setup(1'b1, 1'b0, 4'h4, SEL_GENERIC);
    sem_master_inst.open_frame();
    sem_master_inst.xfer({1'b1, FAULT_REG_OFF, 5'h01}, 16, rx);
    sem_master_inst.xfer(16'h0000, 16, rx);
    sem_master_inst.close_frame();
    check("later read", {13'h0, rx[2:0]}, {13'h0, F_FRAME});
    repeat (6) @(posedge core_clk);
    check("cleared by read", fault_status, 16'h0000);
    $display("test short frame done");
  endtask

  task automatic t_frame_extra();
    setup(1'b1, 1'b1, 4'h4, SEL_GENERIC);
    sem_master_inst.open_frame();
    sem_master_inst.xfer({1'b0, 10'h194, 5'h01}, 16, rx);
    sem_master_inst.xfer(16'h0011, 16, rx);
    sem_master_inst.xfer(16'h0022, 16, rx);
    sem_master_inst.close_frame();
    expect_fault(F_FRAME, 1'b1);
    recover(F_FRAME, 1'b1);
    $display("test extra word done");
  endtask

  task automatic t_timeout();
    setup(1'b0, 1'b1, 4'h4, SEL_GENERIC);
    wframe({1'b0, 10'h194, 5'h02}, 2, F_NONE);
    check("gap within limit", {15'h0, err_state}, 16'h0000);
    setup(1'b0, 1'b1, 4'h1, SEL_GENERIC);
    sem_master_inst.open_frame();
    sem_master_inst.xfer({1'b0, 10'h194, 5'h02}, 16, rx);
    sem_master_inst.xfer(16'h0033, 16, rx);
    #4000;
    expect_fault(F_FRAME, 1'b1);
    sem_master_inst.close_frame();
    setup(1'b0, 1'b1, 4'h4, SEL_GENERIC);
    recover(F_FRAME, 1'b1);
    $display("test timeout done");
  endtask

  task automatic t_cksys();
    setup(1'b1, 1'b1, 4'h4, SEL_GENERIC);
    @(posedge core_clk);
    cksys_ok <= 1'b0;
    repeat (4) @(posedge core_clk);
    sem_master_inst.open_frame();
    sem_master_inst.close_frame();
    expect_fault(F_CKSYS, 1'b1);
    @(posedge core_clk);
    cksys_ok <= 1'b1;
    repeat (4) @(posedge core_clk);
    recover(F_CKSYS, 1'b1);
    $display("test missing clock done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_clean();
    t_word_err();
    t_frame_short();
    t_frame_extra();
    t_timeout();
    t_cksys();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
